// ---- pkg/mpc_pkg.sv ----
package mpc_pkg;

	// ------------------------------------------------------------------
	// Counter and time base geometry
	// ------------------------------------------------------------------
	localparam int          CHANNELS   = 4;
	localparam int          WORD_BITS  = 12;
	localparam logic [11:0] COUNT_FULL = 12'hFFF;
	localparam logic [5:0]  SEC_LAST   = 6'h3B;
	localparam logic [5:0]  MIN_LAST   = 6'h3B;
	localparam logic [3:0]  BIT_LAST   = 4'hB;
	localparam logic [2:0]  WORD_LAST  = 3'h4;

	// ------------------------------------------------------------------
	// Word select codes, one per readout word in shift order
	// ------------------------------------------------------------------
	localparam logic [2:0] SEL_TIME = 3'h4;
	localparam logic [2:0] SEL_CH1  = 3'h0;
	localparam logic [2:0] SEL_CH2  = 3'h2;
	localparam logic [2:0] SEL_CH3  = 3'h6;
	localparam logic [2:0] SEL_CH4  = 3'h1;

	// ------------------------------------------------------------------
	// Register byte offsets and fields
	// ------------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_STATUS  = 12'h004;
	localparam logic [11:0] OFS_IRQ_EN  = 12'h008;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h00C;
	localparam logic [11:0] OFS_TIME    = 12'h010;
	localparam logic [11:0] OFS_COUNT1  = 12'h014;
	localparam logic [11:0] OFS_COUNT2  = 12'h018;
	localparam logic [11:0] OFS_COUNT3  = 12'h01C;
	localparam logic [11:0] OFS_COUNT4  = 12'h020;
	localparam logic [11:0] OFS_RDSTATE = 12'h024;
	localparam int          CTRL_RUN    = 0;
	localparam int          CTRL_START  = 1;
	localparam logic        CTRL_RESET_RUN = 1'b1;
	localparam int          ST_ROLL     = 0;
	localparam int          ST_CHOVF    = 1;
	localparam int          ST_DONE     = 2;
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;

	// ------------------------------------------------------------------
	// Readout state machine
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MPC_IDLE  = 2'b01,
		MPC_SHIFT = 2'b10
	} mpc_state_t;

	// Maps a word index of the readout sequence onto its select code.
	function automatic logic [2:0] mpc_word_select(input logic [2:0] w);
		case (w)
			3'h0:    mpc_word_select = SEL_TIME;
			3'h1:    mpc_word_select = SEL_CH1;
			3'h2:    mpc_word_select = SEL_CH2;
			3'h3:    mpc_word_select = SEL_CH3;
			default: mpc_word_select = SEL_CH4;
		endcase
	endfunction

endpackage

// ---- hdl/mpc_pulse_channel.sv ----
`timescale 1ns/1ps

module mpc_pulse_channel (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        pulse_in,
	input  wire logic        clear,
	output logic [11:0]      count,
	output logic             overflow
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        prev;
		logic [11:0] count;
		logic        overflow;
	} mpc_chan_t;

	mpc_chan_t cur;
	mpc_chan_t next_cur;
	logic      rise;

	// A pulse must stay high for at least one clock to be seen.
	always_comb begin
		next_cur = cur;
		rise = pulse_in & ~cur.prev;
		next_cur.prev = pulse_in;
		next_cur.overflow = 1'b0;
		if (clear) begin
			// A pulse in the clearing cycle opens the new interval.
			next_cur.count = {11'h000, rise};
		end else if (rise) begin
			if (cur.count == mpc_pkg::COUNT_FULL) begin
				next_cur.count = 12'h000;
				next_cur.overflow = 1'b1;
			end else begin
				next_cur.count = 12'(cur.count + 12'h001);
			end
		end
	end

	// Register the whole state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign count    = cur.count;
	assign overflow = cur.overflow;

endmodule

// ---- hdl/mpc_parallel_to_serial_register.sv ----
`timescale 1ns/1ps

module mpc_parallel_to_serial_register (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        load,
	input  wire logic [11:0] load_word,
	input  wire logic        shift,
	output logic             serial_out
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [11:0] data;
	} mpc_parallel_to_serial_register_t;

	mpc_parallel_to_serial_register_t cur;
	mpc_parallel_to_serial_register_t next_cur;

	// Load has priority; the top bit is always the one on the pin.
	always_comb begin
		next_cur = cur;
		if (load) begin
			next_cur.data = load_word;
		end else if (shift) begin
			next_cur.data = {cur.data[10:0], 1'b0};
		end
	end

	// Register the whole state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign serial_out = cur.data[11];

endmodule

// ---- hdl/mpc_pulse_counter.sv ----
`timescale 1ns/1ps

// How it works
// - Four 12-bit counters with overflow detection.
// - Each rising input pulse increments its counter.
// - Time base counts 00:00 through 59:59.
// - Rollover reads out everything, clears all counters.
// - Channel overflow reads out, clears that channel.
// - Parallel-load serial-out register drives readout.
// - Global overflow shows serial data ready.
// - Separate rollover and channel overflow flags.
// - Word select changes every 12 read clocks.
// - Shift/load strobe pulses once per word.
// - Select sequence starts 100, 000, 010.

module mpc_pulse_counter (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        pulse_in_first,
	input  wire logic        pulse_in_second,
	input  wire logic        pulse_in_third,
	input  wire logic        pulse_in_fourth,
	input  wire logic        second_tick,
	input  wire logic        read_clock,
	output logic             serial_out,
	output logic             global_overflow,
	output logic             word_select_bit_zero,
	output logic             word_select_bit_one,
	output logic             word_select_bit_two,
	output logic             shift_load_strobe,
	output logic             rollover_flag,
	output logic             channel_overflow_flag,
	output logic             irq
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	// Everything the block remembers, except the channel counters and the shift register, lives in this
	// one record, so the reset value and the register stage are each written only once.
	typedef struct packed {
		// Bus address phase held over into the data phase.
		logic                 ap_valid;
		logic                 ap_write;
		logic [11:0]          ap_addr;
		logic [31:0]          rdata;
		// Software visible control and interrupt state.
		logic                 ctrl_run;
		logic [2:0]           status;
		logic [2:0]           irq_en;
		// Minutes and seconds of the running interval.
		logic [5:0]           sec;
		logic [5:0]           min;
		// Last levels of the tick and the bit clock, for edge detection.
		logic                 tick_prev;
		logic                 rclk_prev;
		// Readout sequencer and the frozen words that it sends.
		mpc_pkg::mpc_state_t  fsm;
		logic [2:0]           word;
		logic [3:0]           bit_cnt;
		logic [4:0][11:0]     words;
		// Triggers waiting for the sequencer to go idle.
		logic                 pend_all;
		logic [3:0]           ovf_seen;
		// Registered pin values.
		logic                 roll_flag;
		logic                 chovf_flag;
		logic [2:0]           sel;
		logic                 strobe;
	} mpc_top_t;

	mpc_top_t         cur;
	mpc_top_t         next_cur;

	// ------------------------------------------------------------------
	// Channel counters and the output shift register
	// ------------------------------------------------------------------
	logic [3:0]       pulse_vec;
	logic [3:0][11:0] ch_count;
	logic [3:0]       ch_ovf;
	logic [3:0]       ch_clear;
	logic             parallel_to_serial_register_load;
	logic [11:0]      parallel_to_serial_register_word;
	logic             parallel_to_serial_register_shift;

	assign pulse_vec = {pulse_in_fourth, pulse_in_third, pulse_in_second, pulse_in_first};

	// One counter per channel; each wraps to zero and pulses its overflow.
	genvar gi;
	generate
		for (gi = 0; gi < mpc_pkg::CHANNELS; gi++) begin : g_chan
			mpc_pulse_channel u_chan (
				.hclk     (hclk),
				.hresetn  (hresetn),
				.pulse_in (pulse_vec[gi]),
				.clear    (ch_clear[gi]),
				.count    (ch_count[gi]),
				.overflow (ch_ovf[gi])
			);
		end
	endgenerate

	// The shift register holds one word; the sequencer reloads it every word.
	mpc_parallel_to_serial_register parallel_to_serial_register (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.load       (parallel_to_serial_register_load),
		.load_word  (parallel_to_serial_register_word),
		.shift      (parallel_to_serial_register_shift),
		.serial_out (serial_out)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// All next values are worked out in one process; the flop stage
	// below only copies them.
	logic        tick_rise;
	logic        rclk_rise;
	logic        roll;
	logic        accept;
	logic        wr_ok;
	logic        start;
	logic        sw_start;
	logic        done;
	logic [2:0]  word_inc;
	logic [2:0]  clr_bits;
	logic [2:0]  events;
	logic [31:0] rd_mux;

	always_comb begin
		next_cur   = cur;
		tick_rise  = second_tick & ~cur.tick_prev;
		rclk_rise  = read_clock & ~cur.rclk_prev;
		roll       = 1'b0;
		start      = 1'b0;
		sw_start   = 1'b0;
		done       = 1'b0;
		word_inc   = 3'(cur.word + 3'h1);
		clr_bits   = 3'h0;
		ch_clear   = 4'h0;
		parallel_to_serial_register_load  = 1'b0;
		parallel_to_serial_register_word  = cur.words[0];
		parallel_to_serial_register_shift = 1'b0;
		rd_mux     = 32'h0000_0000;
		next_cur.tick_prev = second_tick;
		next_cur.rclk_prev = read_clock;

		// Minutes:seconds time base, advanced by the external tick.
		// Clearing the run bit freezes the time but not the counters.
		if (tick_rise && cur.ctrl_run) begin
			if (cur.sec == mpc_pkg::SEC_LAST) begin
				next_cur.sec = 6'h00;
				if (cur.min == mpc_pkg::MIN_LAST) begin
					next_cur.min = 6'h00;
					roll = 1'b1;
				end else begin
					next_cur.min = 6'(cur.min + 6'h01);
				end
			end else begin
				next_cur.sec = 6'(cur.sec + 6'h01);
			end
		end

		// Bus address phase: only whole-word writes are honoured.
		// A byte or halfword write is dropped but still answered OKAY.
		accept = hsel & hready & htrans[1];
		wr_ok  = cur.ap_valid & cur.ap_write;
		next_cur.ap_valid = accept;
		next_cur.ap_write = hwrite & (hsize == mpc_pkg::HSIZE_WORD);
		next_cur.ap_addr  = haddr[11:0];

		// Register read mux, sampled in the address phase so that the
		// data phase can present a registered word with no wait state.
		case (haddr[11:0])
			mpc_pkg::OFS_CTRL:    rd_mux = {31'h0000_0000, cur.ctrl_run};
			mpc_pkg::OFS_STATUS:  rd_mux = {29'h0000_0000, cur.status};
			mpc_pkg::OFS_IRQ_EN:  rd_mux = {29'h0000_0000, cur.irq_en};
			mpc_pkg::OFS_TIME:    rd_mux = {20'h00000, cur.min, cur.sec};
			mpc_pkg::OFS_COUNT1:  rd_mux = {20'h00000, ch_count[0]};
			mpc_pkg::OFS_COUNT2:  rd_mux = {20'h00000, ch_count[1]};
			mpc_pkg::OFS_COUNT3:  rd_mux = {20'h00000, ch_count[2]};
			mpc_pkg::OFS_COUNT4:  rd_mux = {20'h00000, ch_count[3]};
			mpc_pkg::OFS_RDSTATE: rd_mux = {23'h000000, cur.fsm == mpc_pkg::MPC_SHIFT,
				1'b0, cur.word, cur.bit_cnt};
			default:              rd_mux = 32'h0000_0000;
		endcase
		if (accept && !hwrite) begin
			next_cur.rdata = rd_mux;
		end

		// Bus data phase writes.
		if (wr_ok) begin
			case (cur.ap_addr)
				mpc_pkg::OFS_CTRL: begin
					next_cur.ctrl_run = hwdata[mpc_pkg::CTRL_RUN];
					if (hwdata[mpc_pkg::CTRL_START]) begin
						sw_start = 1'b1;
					end
				end
				mpc_pkg::OFS_IRQ_EN:  next_cur.irq_en = hwdata[2:0];
				mpc_pkg::OFS_IRQ_CLR: clr_bits = hwdata[2:0];
				default:              next_cur.irq_en = cur.irq_en;
			endcase
		end

		// Readout state machine. Triggers are remembered while a
		// readout runs so a second event starts the next one.
		// The bit clock is looked at only while shifting, so edges seen
		// while idle cannot put the next frame out of step.
		case (cur.fsm)
			mpc_pkg::MPC_IDLE: begin
				if (cur.pend_all || (cur.ovf_seen != 4'h0)) begin
					start = 1'b1;
				end
			end
			mpc_pkg::MPC_SHIFT: begin
				if (rclk_rise) begin
					if (cur.bit_cnt == mpc_pkg::BIT_LAST) begin
						next_cur.bit_cnt = 4'h0;
						if (cur.word == mpc_pkg::WORD_LAST) begin
							done = 1'b1;
							next_cur.fsm = mpc_pkg::MPC_IDLE;
							next_cur.word = 3'h0;
							next_cur.sel = mpc_pkg::SEL_TIME;
							next_cur.strobe = 1'b0;
						end else begin
							next_cur.word = word_inc;
							parallel_to_serial_register_load = 1'b1;
							parallel_to_serial_register_word = cur.words[word_inc];
							next_cur.sel = mpc_pkg::mpc_word_select(word_inc);
							next_cur.strobe = 1'b1;
						end
					end else begin
						parallel_to_serial_register_shift = 1'b1;
						next_cur.bit_cnt = 4'(cur.bit_cnt + 4'h1);
						next_cur.strobe = 1'b0;
					end
				end
			end
			default: begin
				next_cur.fsm = mpc_pkg::MPC_IDLE;
			end
		endcase

		// Start of a readout: capture all words, clear all counters if pend_all, load
		// the time word. Capturing first means pulses arriving during
		// the serial transfer are counted into the next interval.
		if (start) begin
			next_cur.words[0] = {cur.min, cur.sec};
			for (int i = 0; i < mpc_pkg::CHANNELS; i++) begin
				next_cur.words[i + 1] = cur.ovf_seen[i] ? mpc_pkg::COUNT_FULL
					: ch_count[i];
			end
			ch_clear = cur.pend_all ? 4'hF : 4'h0;
			next_cur.pend_all = 1'b0;
			next_cur.ovf_seen = 4'h0;
			next_cur.fsm = mpc_pkg::MPC_SHIFT;
			next_cur.word = 3'h0;
			next_cur.bit_cnt = 4'h0;
			next_cur.sel = mpc_pkg::SEL_TIME;
			next_cur.strobe = 1'b1;
			parallel_to_serial_register_load = 1'b1;
			parallel_to_serial_register_word = {cur.min, cur.sec};
		end

		// New events are recorded after any clear so that they win. That
		// includes a start written by software in the very cycle in which
		// an earlier trigger is taken; otherwise that request would be lost.
		if (roll || sw_start) begin
			next_cur.pend_all = 1'b1;
		end
		next_cur.ovf_seen = next_cur.ovf_seen | ch_ovf;

		// Output flags hold until the next readout to finish ends, even if that readout does not report them.
		if (done) begin
			next_cur.roll_flag = 1'b0;
			next_cur.chovf_flag = 1'b0;
		end
		if (roll) begin
			next_cur.roll_flag = 1'b1;
		end
		if (ch_ovf != 4'h0) begin
			next_cur.chovf_flag = 1'b1;
		end

		// Sticky interrupt status; a set in the clearing cycle wins.
		// Done is raised only once the last bit has been clocked out.
		events = 3'h0;
		events[mpc_pkg::ST_ROLL]  = roll;
		events[mpc_pkg::ST_CHOVF] = ch_ovf != 4'h0;
		events[mpc_pkg::ST_DONE]  = done;
		next_cur.status = (cur.status & ~clr_bits) | events;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// The reset value leaves the time base running, so a counter with no
	// software attached still measures and reports its intervals.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= '{
				ctrl_run: mpc_pkg::CTRL_RESET_RUN,
				fsm:      mpc_pkg::MPC_IDLE,
				sel:      mpc_pkg::SEL_TIME,
				default:  '0
			};
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// The slave never stalls and never errors.
	// Every register is a flop or a live count, so a read needs no wait.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = cur.rdata;

	// Pin outputs, all straight from registers except global_overflow and the interrupt.
	// The select pins rest on the time code, so a reader sees the code of
	// the first word before it gives the first bit clock.
	assign global_overflow       = cur.fsm == mpc_pkg::MPC_SHIFT;
	assign word_select_bit_zero  = cur.sel[0];
	assign word_select_bit_one   = cur.sel[1];
	assign word_select_bit_two   = cur.sel[2];
	assign shift_load_strobe     = cur.strobe;
	assign rollover_flag         = cur.roll_flag;
	assign channel_overflow_flag = cur.chovf_flag;
	assign irq                   = |(cur.status & cur.irq_en);

endmodule

// ---- bench/mpc_reader.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Serial reader that sits on the readout pins
// ------------------------------------------------------------------
module mpc_reader (
	input  wire logic       hclk,
	input  wire logic       serial_out,
	input  wire logic       global_overflow,
	input  wire logic       shift_load_strobe,
	input  wire logic [2:0] sel,
	output logic            read_clock
);
	// The bit clock stands low between frames, as a real reader would leave it.
	initial read_clock = 1'b0;

	// Takes one bit per bit clock; gap sets how long each clock half lasts.
	task automatic frame(input int gap, output logic [59:0] bits, output logic [14:0] sels,
			output logic [4:0] stb, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		bits = '0;
		sels = '0;
		stb = '0;
		while (global_overflow !== 1'b1 && n < 20) begin
			@(negedge hclk);
			n++;
		end
		if (n == 20)
			return;
		// Bits are read mid-cycle so the sample never races the edge that moves them.
		for (int i = 0; i < 60; i++) begin
			@(negedge hclk);
			if (i % 12 == 0) begin
				sels = {sels[11:0], sel};
				stb = {stb[3:0], shift_load_strobe};
			end
			bits = {bits[58:0], serial_out};
			@(posedge hclk);
			read_clock <= 1'b1;
			repeat (gap) @(posedge hclk);
			read_clock <= 1'b0;
			repeat (gap) @(posedge hclk);
		end
		ok = 1'b1;
	endtask
endmodule

// ---- bench/mpc_pulse_counter_props.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Port-level checks of the readout and the bus
// ------------------------------------------------------------------
module mpc_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        read_clock,
	input wire logic        serial_out,
	input wire logic        global_overflow,
	input wire logic        word_select_bit_zero,
	input wire logic        word_select_bit_one,
	input wire logic        word_select_bit_two,
	input wire logic        shift_load_strobe,
	input wire logic        rollover_flag,
	input wire logic        channel_overflow_flag
);
	// Select bits gathered so codes compare as one value.
	wire logic [2:0] sel = {word_select_bit_two, word_select_bit_one, word_select_bit_zero};

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence rc_rise;
		$rose(read_clock) && global_overflow;
	endsequence
	sequence word_start;
		$rose(shift_load_strobe) && $past(global_overflow);
	endsequence

	idle_select_a: assert property (!global_overflow |-> sel == 3'h4)
		else $error("select not at time code while idle");
	strobe_busy_a: assert property (shift_load_strobe |-> global_overflow)
		else $error("strobe outside readout");
	strobe_drop_a: assert property (shift_load_strobe ##0 rc_rise |-> ##[1:3] !shift_load_strobe)
		else $error("strobe held past first bit");
	sel_step_a: assert property (global_overflow && $past(global_overflow) && $changed(sel)
		|-> $rose(shift_load_strobe))
		else $error("select moved inside a word");
	word_sel_a: assert property (word_start |-> $changed(sel))
		else $error("new word without new select");
	bit_hold_a: assert property (global_overflow && $past(global_overflow) && $changed(serial_out)
		|-> $past(read_clock) || $past(read_clock, 2) || $past(read_clock, 3))
		else $error("serial bit moved without bit clock");
	roll_start_a: assert property ($rose(rollover_flag) |-> ##[0:3] global_overflow)
		else $error("rollover did not start readout");
	chovf_start_a: assert property ($rose(channel_overflow_flag) |-> ##[0:3] global_overflow)
		else $error("channel wrap did not start readout");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite
		&& haddr[11:0] > 12'h024 && haddr[11:0] < 12'h100 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule

bind mpc_pulse_counter mpc_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .read_clock, .serial_out, .global_overflow,
	.word_select_bit_zero, .word_select_bit_one, .word_select_bit_two, .shift_load_strobe,
	.rollover_flag, .channel_overflow_flag);

// ---- bench/tb.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Bench top: bus master, pulse sources and reader
// ------------------------------------------------------------------
module tb;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [2:0]  hsize   = 3'h2;
	logic [31:0] hwdata  = 32'h0;
	logic [4:0]  stim    = 5'h00;
	wire logic   hready, hresp, ser, gov, ws0, ws1, ws2, slst, rflag, cflag, irq, rclk;
	wire logic [31:0] hrdata;
	int          n_fail = 0;
	int          cmp_count = 0;

	always #12.5 hclk = ~hclk;

	mpc_pulse_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pulse_in_first(stim[0]),
		.pulse_in_second(stim[1]), .pulse_in_third(stim[2]), .pulse_in_fourth(stim[3]),
		.second_tick(stim[4]), .read_clock(rclk), .serial_out(ser), .global_overflow(gov),
		.word_select_bit_zero(ws0), .word_select_bit_one(ws1), .word_select_bit_two(ws2),
		.shift_load_strobe(slst), .rollover_flag(rflag), .channel_overflow_flag(cflag),
		.irq(irq));
	mpc_reader rdr (.hclk(hclk), .serial_out(ser), .global_overflow(gov),
		.shift_load_strobe(slst), .sel({ws2, ws1, ws0}), .read_clock(rclk));

	task automatic conclude;
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One single word transfer; the slave may stretch either phase, so both are waited on.
	// It returns mid-cycle, so a check right after it sees settled outputs.
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		@(negedge hclk);
		if (hready !== 1'b1) begin
			n_fail++;
			conclude();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		chk(64'(rd), 64'(exp));
	endtask

	// Mask m picks the channels (bits 3:0) and the second tick (bit 4).
	task automatic pulse(input logic [4:0] m, input int n);
		repeat (n) begin
			@(posedge hclk);
			stim <= m;
			@(posedge hclk);
			stim <= 5'h00;
		end
	endtask

	task automatic readout(input int gap, input logic [59:0] exp);
		logic [59:0] b;
		logic [14:0] s;
		logic [4:0]  t;
		logic        ok;
		rdr.frame(gap, b, s, t, ok);
		if (ok !== 1'b1) begin
			n_fail++;
			conclude();
		end
		chk(64'(b), 64'(exp));
		chk(64'(s), 64'h40B1);
		chk(64'(t), 64'h1F);
		repeat (4) @(negedge hclk);
		chk(64'(gov), 64'h0);
	endtask

	initial begin
		repeat (100000) @(posedge hclk);
		n_fail++;
		conclude();
	end

	// Main sequence: reset state, counting, forced, channel and rollover readouts.
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(mpc_pkg::OFS_CTRL, 32'h1);
		rdc(mpc_pkg::OFS_TIME, 32'h0);
		for (int k = 0; k < 4; k++)
			rdc(mpc_pkg::OFS_COUNT1 + 12'(4 * k), 32'h0);
		rdc(12'h028, 32'h0);
		wr(mpc_pkg::OFS_STATUS, 32'h7);
		rdc(mpc_pkg::OFS_STATUS, 32'h0);
		pulse(5'h10, 75);
		pulse(5'h0F, 1);
		pulse(5'h0D, 1);
		pulse(5'h09, 1);
		pulse(5'h08, 2);
		rdc(mpc_pkg::OFS_TIME, 32'h04F);
		rdc(mpc_pkg::OFS_COUNT1, 32'h3);
		rdc(mpc_pkg::OFS_COUNT2, 32'h1);
		rdc(mpc_pkg::OFS_COUNT3, 32'h2);
		rdc(mpc_pkg::OFS_COUNT4, 32'h5);
		wr(mpc_pkg::OFS_IRQ_EN, 32'h4);
		// A halfword write must be dropped without disturbing the register.
		@(posedge hclk);
		hsize <= 3'h1;
		wr(mpc_pkg::OFS_IRQ_EN, 32'h0);
		@(posedge hclk);
		hsize <= 3'h2;
		rdc(mpc_pkg::OFS_IRQ_EN, 32'h4);
		wr(mpc_pkg::OFS_CTRL, 32'h3);
		readout(2, 60'h04F_003_001_002_005);
		rdc(mpc_pkg::OFS_CTRL, 32'h1);
		rdc(mpc_pkg::OFS_STATUS, 32'h4);
		rdc(mpc_pkg::OFS_COUNT4, 32'h0);
		chk(64'(irq), 64'h1);
		wr(mpc_pkg::OFS_IRQ_EN, 32'h0);
		chk(64'(irq), 64'h0);
		wr(mpc_pkg::OFS_IRQ_EN, 32'h4);
		chk(64'(irq), 64'h1);
		wr(mpc_pkg::OFS_IRQ_CLR, 32'h4);
		chk(64'(irq), 64'h0);
		// A wrapping channel must start a readout on its own and clear only itself.
		pulse(5'h02, 2);
		pulse(5'h08, 4096);
		repeat (2) @(negedge hclk);
		chk(64'(cflag), 64'h1);
		chk(64'(rflag), 64'h0);
		readout(5, 60'h04F_000_002_000_FFF);
		chk(64'(cflag), 64'h0);
		rdc(mpc_pkg::OFS_STATUS, 32'h6);
		rdc(mpc_pkg::OFS_COUNT2, 32'h2);
		rdc(mpc_pkg::OFS_COUNT4, 32'h0);
		// The last second of the hour rolls the time base over.
		pulse(5'h01, 1);
		pulse(5'h10, 3524);
		rdc(mpc_pkg::OFS_TIME, 32'hEFB);
		pulse(5'h10, 1);
		@(negedge hclk);
		chk(64'(rflag), 64'h1);
		readout(3, 60'h000_001_002_000_000);
		chk(64'(rflag), 64'h0);
		rdc(mpc_pkg::OFS_COUNT1, 32'h0);
		rdc(mpc_pkg::OFS_TIME, 32'h0);
		rdc(mpc_pkg::OFS_RDSTATE, 32'h0);
		// With the run bit off a tick must leave the time base alone.
		wr(mpc_pkg::OFS_CTRL, 32'h0);
		pulse(5'h10, 1);
		rdc(mpc_pkg::OFS_CTRL, 32'h0);
		rdc(mpc_pkg::OFS_TIME, 32'h0);
		conclude();
	end
endmodule
